/* design/rst_defines.vh */
// Register map, field positions, codes and reset values of the relay setpoint timer.
`ifndef RST_DEFINES_VH
`define RST_DEFINES_VH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define RST_A_CTRL    6'h00
`define RST_A_SP1     6'h04
`define RST_A_SP2     6'h08
`define RST_A_BAND    6'h0c
`define RST_A_DUTY    6'h10
`define RST_A_ONDLY   6'h14
`define RST_A_OFFDLY  6'h18
`define RST_A_TIME    6'h20
`define RST_A_EVSEL   6'h24
`define RST_A_EVCFG   6'h28
`define RST_A_EVDUR   6'h2c
`define RST_A_STAT    6'h30
`define RST_A_ACCUM   6'h34
`define RST_A_CYCON   6'h38
`define RST_A_REMAIN  6'h3c
// ----------------------------------------------------------------------------
// Control fields and codes
// ----------------------------------------------------------------------------
`define RST_C_TIMER   0
`define RST_C_OUTRNG  1
`define RST_C_CLIMATE 4
`define RST_C_SEL_LO  2
`define RST_SEL_AUTO  2'h0
`define RST_SEL_HAND  2'h1
`define RST_SEL_OFF   2'h2
`define RST_CTRL_RST  32'h00000000
`define RST_PCT_FULL  8'h64
// ----------------------------------------------------------------------------
// Event repetition codes
// ----------------------------------------------------------------------------
`define RST_REP_NONE  3'h0
`define RST_REP_HOUR  3'h1
`define RST_REP_DAY   3'h2
`define RST_REP_W1    3'h3
`define RST_REP_W2    3'h4
`define RST_REP_W4    3'h5
// ----------------------------------------------------------------------------
// Time base
// ----------------------------------------------------------------------------
`define RST_CLK_HZ    50000000
`define RST_SEC_DAY   17'h1517f
`define RST_SEC_HOUR  17'h00e10
`define RST_NUM_EV    10
`endif

/* design/rst_relay_ctrl.v */
// Relay control: dual-threshold and scheduled-event modes behind an Avalon-MM slave.
`timescale 1ns/10ps
`default_nettype none
`include "rst_defines.vh"

module rst_relay_ctrl #(
    parameter integer CLK_HZ = `RST_CLK_HZ,
    parameter integer PV_W   = 16
) (
    // Clock and reset
    input  wire             i_core_clk,
    input  wire             i_rst_n,
    // Avalon-MM slave
    input  wire [5:0]       i_avs_address,
    input  wire             i_avs_read,
    input  wire             i_avs_write,
    input  wire [31:0]      i_avs_writedata,
    input  wire [3:0]       i_avs_byteenable,
    output reg  [31:0]      o_avs_readdata,
    output wire             o_avs_waitrequest,
    // Process inputs
    input  wire [PV_W-1:0]  i_pv,
    input  wire             i_interlock,
    input  wire             i_force_on,
    // Outputs
    output reg              o_relay,
    output reg              o_skip_alarm
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function [16:0] hms_sec;
        input [23:0] v;
        begin
            hms_sec = v[23:16] * 17'd3600 + v[15:8] * 17'd60 + {9'h000, v[7:0]};
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    reg [PV_W-1:0] pv_m_r, pv_r;
    reg [1:0]      ilk_m_r, ilk_r;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pv_m_r  <= {PV_W{1'b0}};
            pv_r    <= {PV_W{1'b0}};
            ilk_m_r <= 2'h0;
            ilk_r   <= 2'h0;
        end else begin
            pv_m_r  <= i_pv;
            pv_r    <= pv_m_r;
            ilk_m_r <= {i_force_on, i_interlock};
            ilk_r   <= ilk_m_r;
        end
    end

    wire interlock = ilk_r[0];
    wire force_on  = ilk_r[1];

    // ------------------------------------------------------------------------
    // Register file and bus handshake
    // ------------------------------------------------------------------------
    reg [31:0] ctrl_r, sp1_r, sp2_r, band_r, duty_r, ondly_r, offdly_r;
    reg [3:0]  evsel_r;
    reg [29:0] evcfg_r [0:`RST_NUM_EV-1];
    reg [16:0] evdur_r [0:`RST_NUM_EV-1];
    reg        ack_r;

    wire req      = i_avs_read | i_avs_write;
    // A write lands only at the edge where waitrequest is seen low.
    wire wr_stb   = i_avs_write & ack_r;
    wire time_wr  = wr_stb & (i_avs_address == `RST_A_TIME);
    assign o_avs_waitrequest = req & ~ack_r;

    integer e;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_r    <= 1'b0;
            ctrl_r   <= `RST_CTRL_RST;
            sp1_r    <= 32'h0;
            sp2_r    <= 32'h0;
            band_r   <= 32'h0;
            duty_r   <= {8'h0, `RST_PCT_FULL, 16'h0};
            ondly_r  <= 32'h0;
            offdly_r <= 32'h0;
            evsel_r  <= 4'h0;
            for (e = 0; e < `RST_NUM_EV; e = e + 1) begin
                evcfg_r[e] <= 30'h0;
                evdur_r[e] <= 17'h0;
            end
        end else begin
            ack_r <= req & ~ack_r;
            if (wr_stb) begin
                case (i_avs_address)
                    `RST_A_CTRL:   ctrl_r   <= merge(ctrl_r, i_avs_writedata, i_avs_byteenable);
                    `RST_A_SP1:    sp1_r    <= merge(sp1_r, i_avs_writedata, i_avs_byteenable);
                    `RST_A_SP2:    sp2_r    <= merge(sp2_r, i_avs_writedata, i_avs_byteenable);
                    `RST_A_BAND:   band_r   <= merge(band_r, i_avs_writedata, i_avs_byteenable);
                    `RST_A_DUTY:   duty_r   <= merge(duty_r, i_avs_writedata, i_avs_byteenable);
                    `RST_A_ONDLY:  ondly_r  <= merge(ondly_r, i_avs_writedata, i_avs_byteenable);
                    `RST_A_OFFDLY: offdly_r <= merge(offdly_r, i_avs_writedata, i_avs_byteenable);
                    `RST_A_EVSEL:  evsel_r  <= (i_avs_writedata[3:0] < `RST_NUM_EV) ? i_avs_writedata[3:0] : 4'h0;
                    `RST_A_EVCFG:  evcfg_r[evsel_r] <= i_avs_writedata[29:0];
                    `RST_A_EVDUR:  evdur_r[evsel_r] <= i_avs_writedata[16:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // One-second tick and calendar
    // ------------------------------------------------------------------------
    reg [25:0] div_r;
    reg        tick_r;
    reg [16:0] sod_r;
    reg [2:0]  dow_r;
    reg [1:0]  week_r;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r  <= 26'h0;
            tick_r <= 1'b0;
            sod_r  <= 17'h0;
            dow_r  <= 3'h0;
            week_r <= 2'h0;
        end else begin
            tick_r <= (div_r == CLK_HZ[25:0] - 26'h1);
            div_r  <= (div_r == CLK_HZ[25:0] - 26'h1) ? 26'h0 : div_r + 26'h1;
            if (time_wr) begin
                sod_r  <= i_avs_writedata[16:0];
                dow_r  <= i_avs_writedata[26:24];
                week_r <= i_avs_writedata[29:28];
            end else if (tick_r) begin
                sod_r <= (sod_r == `RST_SEC_DAY) ? 17'h0 : sod_r + 17'h1;
                if (sod_r == `RST_SEC_DAY) begin
                    dow_r <= (dow_r == 3'h6) ? 3'h0 : dow_r + 3'h1;
                    if (dow_r == 3'h6)
                        week_r <= week_r + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Dual-threshold demand
    // ------------------------------------------------------------------------
    wire [17:0] sp_lo   = (sp1_r[15:0] < sp2_r[15:0]) ? {2'h0, sp1_r[15:0]} : {2'h0, sp2_r[15:0]};
    wire [17:0] sp_hi   = (sp1_r[15:0] < sp2_r[15:0]) ? {2'h0, sp2_r[15:0]} : {2'h0, sp1_r[15:0]};
    wire [17:0] band    = {2'h0, band_r[15:0]};
    wire [17:0] pv      = {{(18-PV_W){1'b0}}, pv_r};
    wire        out_rng = ctrl_r[`RST_C_OUTRNG];
    reg         demand_r;
    reg         dem_nxt;

    always @* begin
        dem_nxt = demand_r;
        if (!out_rng) begin
            if (!demand_r)
                dem_nxt = (pv >= sp_lo) && (pv <= sp_hi);
            else
                dem_nxt = (pv + band >= sp_lo) && (pv <= sp_hi + band);
        end else begin
            if (!demand_r)
                dem_nxt = (pv <= sp_lo) || (pv >= sp_hi);
            else
                dem_nxt = (pv < sp_lo + band) || (pv + band > sp_hi);
        end
    end

    // ------------------------------------------------------------------------
    // Delays and duty cycle
    // ------------------------------------------------------------------------
    wire [16:0] on_dly  = hms_sec(ondly_r[23:0]);
    wire [16:0] off_dly = hms_sec(offdly_r[23:0]);
    wire [12:0] period  = duty_r[15:8] * 13'd60 + {5'h00, duty_r[7:0]};
    wire [7:0]  pct     = duty_r[23:16];
    reg         dual_on_r;
    reg [16:0]  dly_r;
    reg [12:0]  cyc_r;
    wire        dly_done = (dual_on_r ? (dly_r >= off_dly) : (dly_r >= on_dly));
    wire        duty_ok  = (period == 13'h0) || (pct >= `RST_PCT_FULL) ||
                           ({7'h00, cyc_r} * 20'd100 < {7'h00, period} * {12'h000, pct});

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            demand_r  <= 1'b0;
            dual_on_r <= 1'b0;
            dly_r     <= 17'h0;
            cyc_r     <= 13'h0;
        end else begin
            demand_r <= dem_nxt;
            if (demand_r == dual_on_r) begin
                dly_r <= 17'h0;
            end else if (dly_done) begin
                dual_on_r <= demand_r;
                dly_r     <= 17'h0;
            end else if (tick_r) begin
                dly_r <= dly_r + 17'h1;
            end
            if (period == 13'h0 || !dual_on_r)
                cyc_r <= 13'h0;
            else if (tick_r)
                cyc_r <= (cyc_r >= period - 13'h1) ? 13'h0 : cyc_r + 13'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Scheduled events
    // ------------------------------------------------------------------------
    function ev_hit;
        input [29:0] c;
        input [16:0] sod;
        input [2:0]  dow;
        input [1:0]  wk;
        begin
            case (c[22:20])
                `RST_REP_HOUR: ev_hit = (sod % `RST_SEC_HOUR) == (c[16:0] % `RST_SEC_HOUR);
                `RST_REP_DAY:  ev_hit = sod == c[16:0];
                `RST_REP_W1:   ev_hit = (sod == c[16:0]) && (dow == c[26:24]);
                `RST_REP_W2:   ev_hit = (sod == c[16:0]) && (dow == c[26:24]) && (wk[0] == c[28]);
                `RST_REP_W4:   ev_hit = (sod == c[16:0]) && (dow == c[26:24]) && (wk == c[29:28]);
                default:       ev_hit = 1'b0;
            endcase
        end
    endfunction

    reg [`RST_NUM_EV-1:0] hit;
    reg [16:0]            hit_dur;
    integer h;
    always @* begin
        hit     = {`RST_NUM_EV{1'b0}};
        hit_dur = 17'h0;
        for (h = `RST_NUM_EV - 1; h >= 0; h = h - 1) begin
            hit[h] = ev_hit(evcfg_r[h], sod_r, dow_r, week_r) && (evdur_r[h] != 17'h0);
            if (hit[h])
                hit_dur = evdur_r[h];
        end
    end

    wire       timer_mode = ctrl_r[`RST_C_TIMER] & ~ctrl_r[`RST_C_CLIMATE];
    wire [1:0] hand_off_auto_select = ctrl_r[`RST_C_SEL_LO +: 2];
    wire       ev_start   = tick_r & timer_mode & (|hit);
    reg [16:0] remain_r;
    reg        seen_r;
    wire       ev_act = (remain_r != 17'h0);
    wire       ev_end = tick_r & (remain_r == 17'h1);

    // ------------------------------------------------------------------------
    // Relay arbitration
    // ------------------------------------------------------------------------
    reg relay_nxt;
    always @* begin
        case (hand_off_auto_select)
            `RST_SEL_HAND: relay_nxt = 1'b1;
            `RST_SEL_OFF:  relay_nxt = 1'b0;
            default: begin
                if (interlock)
                    relay_nxt = 1'b0;
                else if (force_on)
                    relay_nxt = 1'b1;
                else if (timer_mode)
                    relay_nxt = ev_act;
                else
                    relay_nxt = dual_on_r & duty_ok;
            end
        endcase
    end

    wire skip_set = (ev_start & ev_act) | (ev_end & ~seen_r & ~o_relay);
    wire relay_up = relay_nxt & ~o_relay;

    // ------------------------------------------------------------------------
    // Event timer, alarm and on-time accounting
    // ------------------------------------------------------------------------
    reg [31:0] accum_r;
    reg [31:0] cycon_r;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            remain_r     <= 17'h0;
            seen_r       <= 1'b0;
            o_relay      <= 1'b0;
            o_skip_alarm <= 1'b0;
            accum_r      <= 32'h0;
            cycon_r      <= 32'h0;
        end else begin
            o_relay <= relay_nxt;
            if (!timer_mode) begin
                remain_r <= 17'h0;
            end else if (ev_start && !ev_act) begin
                remain_r <= hit_dur;
                seen_r   <= 1'b0;
            end else if (tick_r && ev_act) begin
                remain_r <= remain_r - 17'h1;
            end
            if (ev_act && o_relay)
                seen_r <= 1'b1;
            if (skip_set)
                o_skip_alarm <= 1'b1;
            else if (relay_up)
                o_skip_alarm <= 1'b0;
            if (relay_up)
                cycon_r <= 32'h0;
            else if (tick_r && o_relay)
                cycon_r <= cycon_r + 32'h1;
            if (tick_r && o_relay)
                accum_r <= accum_r + 32'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    wire [16:0] cyc_left = timer_mode ? remain_r :
                           (period == 13'h0) ? 17'h0 : {4'h0, period - cyc_r};

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0;
        end else if (i_avs_read && !ack_r) begin
            case (i_avs_address)
                `RST_A_CTRL:   o_avs_readdata <= ctrl_r;
                `RST_A_SP1:    o_avs_readdata <= sp1_r;
                `RST_A_SP2:    o_avs_readdata <= sp2_r;
                `RST_A_BAND:   o_avs_readdata <= band_r;
                `RST_A_DUTY:   o_avs_readdata <= duty_r;
                `RST_A_ONDLY:  o_avs_readdata <= ondly_r;
                `RST_A_OFFDLY: o_avs_readdata <= offdly_r;
                `RST_A_TIME:   o_avs_readdata <= {2'h0, week_r, 1'b0, dow_r, 7'h00, sod_r};
                `RST_A_EVSEL:  o_avs_readdata <= {28'h0, evsel_r};
                `RST_A_EVCFG:  o_avs_readdata <= {2'h0, evcfg_r[evsel_r]};
                `RST_A_EVDUR:  o_avs_readdata <= {15'h0, evdur_r[evsel_r]};
                `RST_A_STAT:   o_avs_readdata <= {25'h0, timer_mode, ev_act, dual_on_r,
                                                  demand_r, interlock, o_skip_alarm, o_relay};
                `RST_A_ACCUM:  o_avs_readdata <= accum_r;
                `RST_A_CYCON:  o_avs_readdata <= cycon_r;
                `RST_A_REMAIN: o_avs_readdata <= {15'h0, cyc_left};
                default:       o_avs_readdata <= 32'h0;
            endcase
        end
    end

endmodule // rst_relay_ctrl
`default_nettype wire

/* tb/rst_relay_ctrl_props.sv */
// Concurrent checks on the ports of the relay setpoint timer block.
`timescale 1ns/10ps
`default_nettype none
module rst_relay_props #(
    parameter integer PV_W = 16
) (
    // Clock and reset
    input wire logic            i_core_clk,
    input wire logic            i_rst_n,
    // Avalon-MM slave
    input wire logic [5:0]      i_avs_address,
    input wire logic            i_avs_read,
    input wire logic            i_avs_write,
    input wire logic [31:0]     i_avs_writedata,
    input wire logic [3:0]      i_avs_byteenable,
    input wire logic [31:0]     o_avs_readdata,
    input wire logic            o_avs_waitrequest,
    // Process inputs and outputs
    input wire logic [PV_W-1:0] i_pv,
    input wire logic            i_interlock,
    input wire logic            i_force_on,
    input wire logic            o_relay,
    input wire logic            o_skip_alarm
);
    // ------------------------------------------------------------------------
    // Shadow of the hand-off-auto field, taken from completed writes.
    // ------------------------------------------------------------------------
    logic [1:0] mode_sel_r;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) mode_sel_r <= 2'h0;
        else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 6'h00 && i_avs_byteenable[0])
            mode_sel_r <= i_avs_writedata[3:2];
    end
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    AST_WAIT_RISE: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
        else $error("new request not stalled");
    AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("more than one wait state");
    AST_IDLE_NOWAIT: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait without request");
    AST_RD_HOLD: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
        else $error("read data moved without a read");
    AST_ILOCK_OFF: assert property ((mode_sel_r == 2'h0 && i_interlock)[*4] |-> !o_relay)
        else $error("relay on under interlock");
    AST_FORCE_ON: assert property ((mode_sel_r == 2'h0 && i_force_on && !i_interlock)[*4] |-> o_relay)
        else $error("relay off under force-on");
    AST_HAND_ON: assert property ((mode_sel_r == 2'h1)[*3] |-> o_relay)
        else $error("relay off in hand mode");
    AST_OFF_MODE: assert property ((mode_sel_r == 2'h2)[*3] |-> !o_relay)
        else $error("relay on in off mode");
    AST_ALARM_CLR: assert property ($fell(o_skip_alarm) |-> o_relay)
        else $error("alarm cleared without relay activation");
endmodule // rst_relay_props
bind rst_relay_ctrl rst_relay_props #(.PV_W(PV_W)) u_props (.*);
`default_nettype wire

/* tb/tb_relay_setpoint_timer_control.sv */
// Self-checking bench for the relay setpoint timer block.
`timescale 1ns/10ps
`default_nettype none
`include "rst_defines.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_relay_setpoint_timer_control;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic [5:0]  addr     = 6'h00;
    logic        rd       = 1'b0;
    logic        wr       = 1'b0;
    logic [31:0] wdata    = 32'h0;
    logic [15:0] pv       = 16'h0;
    logic        ilock    = 1'b0;
    logic        force_on = 1'b0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        relay;
    logic        alarm;
    logic [31:0] q;
    int          err_total = 0;
    int          cmp_count = 0;
    int          n;
    rst_relay_ctrl #(.CLK_HZ(20), .PV_W(16)) u_dut (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_pv(pv), .i_interlock(ilock), .i_force_on(force_on), .o_relay(relay), .o_skip_alarm(alarm)
    );
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task end_of_test;
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Holds the request until waitrequest is seen low at a rising edge.
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge core_clk);
        while (waitreq !== 1'b0 && k < 20) begin
            @(posedge core_clk);
            k++;
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk);
        `CHK(k < 20, 1'b1)
    endtask
    task rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q & m, e)
    endtask
    // Waits up to mx cycles for the relay level, then checks it holds for hold cycles.
    task rly(input logic e, input int mx, input int hold);
        int k;
        int bad;
        k = 0;
        bad = 0;
        while (relay !== e && k < mx) begin
            @(posedge core_clk);
            k++;
        end
        `CHK(relay, e)
        repeat (hold) begin
            @(posedge core_clk);
            if (relay !== e) bad++;
        end
        `CHK(bad, 0)
    endtask
    initial begin
        #200us;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd_chk(`RST_A_CTRL, 32'hffffffff, `RST_CTRL_RST);
        rd_chk(`RST_A_DUTY, 32'hffffffff, 32'h00640000);
        bus(1'b1, 6'h1c, 32'h12345678);
        rd_chk(6'h1c, 32'hffffffff, 32'h0);
        bus(1'b1, `RST_A_SP1, 32'd100);
        bus(1'b1, `RST_A_SP2, 32'd200);
        bus(1'b1, `RST_A_BAND, 32'd10);
        rd_chk(`RST_A_SP2, 32'hffff, 32'd200);
        pv <= 16'd150;
        rly(1'b1, 20, 0);
        pv <= 16'd95;
        rly(1'b1, 0, 20);
        pv <= 16'd85;
        rly(1'b0, 10, 0);
        pv <= 16'd105;
        rly(1'b1, 10, 0);
        pv <= 16'd215;
        rly(1'b0, 10, 0);
        bus(1'b1, `RST_A_CTRL, 32'h2);
        rly(1'b1, 10, 0);
        pv <= 16'd195;
        rly(1'b1, 0, 20);
        pv <= 16'd150;
        rly(1'b0, 10, 0);
        pv <= 16'd90;
        rly(1'b1, 10, 0);
        bus(1'b1, `RST_A_DUTY, 32'h00320000);
        rly(1'b1, 0, 200);
        bus(1'b1, `RST_A_DUTY, 32'h00320004);
        rly(1'b0, 100, 0);
        rly(1'b1, 100, 0);
        n = 0;
        repeat (160) begin
            @(posedge core_clk);
            if (relay === 1'b1) n++;
        end
        `CHK(n, 80)
        bus(1'b1, `RST_A_DUTY, 32'h00640004);
        rly(1'b1, 100, 200);
        pv <= 16'd150;
        rly(1'b0, 10, 0);
        bus(1'b1, `RST_A_ONDLY, 32'h2);
        bus(1'b1, `RST_A_OFFDLY, 32'h2);
        pv <= 16'd90;
        rly(1'b0, 0, 18);
        rly(1'b1, 60, 0);
        pv <= 16'd150;
        rly(1'b1, 0, 18);
        rly(1'b0, 60, 0);
        bus(1'b1, `RST_A_ONDLY, 32'h0);
        bus(1'b1, `RST_A_OFFDLY, 32'h0);
        bus(1'b1, `RST_A_CTRL, 32'h11);
        rd_chk(`RST_A_STAT, 32'h40, 32'h0);
        bus(1'b1, `RST_A_CTRL, 32'h01);
        rd_chk(`RST_A_STAT, 32'h40, 32'h40);
        bus(1'b1, `RST_A_TIME, 32'h13000064);
        bus(1'b1, `RST_A_EVSEL, 32'd0);
        bus(1'b1, `RST_A_EVCFG, 32'h13500067);
        bus(1'b1, `RST_A_EVDUR, 32'd3);
        bus(1'b1, `RST_A_EVSEL, 32'd1);
        bus(1'b1, `RST_A_EVCFG, 32'h00100068);
        bus(1'b1, `RST_A_EVDUR, 32'd1);
        rd_chk(`RST_A_EVCFG, 32'hffffffff, 32'h00100068);
        rly(1'b1, 120, 0);
        n = 0;
        while (relay === 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        `CHK(n, 60)
        `CHK(alarm, 1'b1)
        rd_chk(`RST_A_TIME, 32'h33000000, 32'h13000000);
        bus(1'b1, `RST_A_EVSEL, 32'd10);
        rd_chk(`RST_A_EVSEL, 32'hffffffff, 32'h0);
        bus(1'b1, `RST_A_CTRL, 32'h05);
        rly(1'b1, 10, 0);
        `CHK(alarm, 1'b0)
        rd_chk(`RST_A_STAT, 32'h1, 32'h1);
        bus(1'b0, `RST_A_ACCUM, 32'h0);
        `CHK(q != 32'h0, 1'b1)
        bus(1'b1, `RST_A_CTRL, 32'h01);
        bus(1'b1, `RST_A_EVSEL, 32'd1);
        bus(1'b1, `RST_A_EVDUR, 32'd0);
        ilock <= 1'b1;
        bus(1'b1, `RST_A_TIME, 32'h13000064);
        rly(1'b0, 20, 160);
        `CHK(alarm, 1'b1)
        ilock <= 1'b0;
        bus(1'b1, `RST_A_TIME, 32'h13000064);
        force_on <= 1'b1;
        rly(1'b1, 10, 0);
        `CHK(alarm, 1'b0)
        rly(1'b1, 0, 150);
        rd_chk(`RST_A_STAT, 32'h20, 32'h0);
        rd_chk(`RST_A_REMAIN, 32'h1ffff, 32'h0);
        force_on <= 1'b0;
        rly(1'b0, 10, 0);
        bus(1'b1, `RST_A_CTRL, 32'h09);
        force_on <= 1'b1;
        rly(1'b0, 10, 20);
        end_of_test;
    end
endmodule // tb_relay_setpoint_timer_control
`default_nettype wire
